// ==== hdl/ccs_consts.vh ====
`ifndef CCS_CONSTS_VH
`define CCS_CONSTS_VH

// Strap codes for the CPU clock mode
`define CCS_MODE_X4 3'b111
`define CCS_MODE_X3 3'b110
`define CCS_MODE_X2 3'b101
`define CCS_MODE_X5 3'b100
`define CCS_MODE_DIRECT 3'b011
`define CCS_MODE_X15 3'b010
`define CCS_MODE_PRESCALE 3'b001
`define CCS_MODE_X25 3'b000
`define CCS_MODE_RESET 3'b111

// PLL factors in halves (factor times two)
`define CCS_FH_X4 4'h8
`define CCS_FH_X3 4'h6
`define CCS_FH_X2 4'h4
`define CCS_FH_X5 4'ha
`define CCS_FH_X15 4'h3
`define CCS_FH_X25 4'h5
`define CCS_FH_NONE 4'h2

// System configuration register field
`define CCS_MONDIS_BIT 4
`define CCS_SYSCFG_RESET 16'h0000
`define CCS_MONDIS_RESET 1'b0

// Oscillator monitor timing
`define CCS_MON_OVF 5'h10
`define CCS_FREE_HALF 4'h2

`endif

// ==== hdl/ccs_osc_monitor.v ====
`timescale 1ns/1ns
`include "ccs_consts.vh"

module ccs_osc_monitor #(
   parameter [3:0] FREE_HALF = `CCS_FREE_HALF,
   parameter [4:0] OVF_COUNT = `CCS_MON_OVF
) (
   // Clock and reset
   input wire clk_sys,
   input wire resetn,
   // Control
   input wire runFree,
   input wire countEn,
   input wire xtalEdge,
   // Events
   output reg freeTick_q,
   output reg overflow_q
);

   reg [3:0] halfCnt_q;
   reg freePhase_q;
   reg [4:0] monCnt_q;
   reg [3:0] halfCnt_d;
   reg [4:0] monCnt_d;
   wire halfDone;

   ////////////////////////////////////////////////////////////////////////////
   // Free-running PLL model: one tick per half period
   assign halfDone = runFree && (halfCnt_q == FREE_HALF - 4'h1);

   always @* begin
      halfCnt_d = halfCnt_q;
      if (!runFree || halfDone) begin
         halfCnt_d = 4'h0;
      end else begin
         halfCnt_d = halfCnt_q + 4'h1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Monitor counter, one count per full free-running cycle
   always @* begin
      monCnt_d = monCnt_q;
      if (!countEn || xtalEdge) begin
         monCnt_d = 5'h00;
      end else if (halfDone && freePhase_q && monCnt_q != OVF_COUNT) begin
         monCnt_d = monCnt_q + 5'h01;
      end
   end

   always @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         halfCnt_q <= 4'h0;
         freePhase_q <= 1'b0;
         monCnt_q <= 5'h00;
         freeTick_q <= 1'b0;
         overflow_q <= 1'b0;
      end else begin
         halfCnt_q <= halfCnt_d;
         freePhase_q <= runFree ? (freePhase_q ^ halfDone) : 1'b0;
         monCnt_q <= monCnt_d;
         freeTick_q <= halfDone;
         // Overflow pulses once when the count first reaches its limit
         overflow_q <= countEn && !xtalEdge && monCnt_d == OVF_COUNT
            && monCnt_q != OVF_COUNT;
      end
   end

endmodule // ccs_osc_monitor

// ==== hdl/ccs_clock_select.v ====
// Contract
// - Strap code on three port-0 pins during reset picks the CPU clock mode.
// - PLL mode multiplies input clock by 4,3,2,5,1.5 or 2.5 per strap code.
// - Code 001 divides input clock by two; each phase is one input period.
// - Code 011 disables PLL; CPU clock follows the input clock directly.
// - PLL resynchronises to the input clock every F input transitions; code uses 4 for F of 1.5 and 6 for F of 2.5.
// - Oscillator failover applies only in direct or divide-by-two modes.
// - Monitor enabled after reset; software sets config bit 4 to disable.
// - Enabled monitor runs PLL free; counter counts, cleared on input transitions.
// - Counter overflow after 16 cycles switches to free clock, sets interrupt flag.
// - Failover holds until hardware reset, even if the input clock returns.
// - Monitor disabled: CPU clock from oscillator input, PLL powered down.
`timescale 1ns/1ns
`include "ccs_consts.vh"

module ccs_clock_select #(
   parameter PERIOD_WIDTH = 12,
   parameter [3:0] FREE_HALF = `CCS_FREE_HALF,
   parameter [4:0] OVF_COUNT = `CCS_MON_OVF
) (
   // Clock and reset
   input wire clk_sys,
   input wire resetn,
   // Pins from the board
   input wire [2:0] clockStrapPins,
   input wire crystalInputPin,
   // System configuration write and flag clear
   input wire sysConfigWrite,
   input wire [15:0] sysConfigData,
   input wire irqFlagClear,
   // Clock and status outputs
   output reg cpuClock_q,
   output reg pllEnable_q,
   output reg [2:0] clockMode_q,
   output reg modeValid_q,
   output reg oscMonitorDisable_q,
   output reg monitorActive_q,
   output reg clockFailed_q,
   output reg clockFailIrqFlag_q
);

   localparam ACC_WIDTH = PERIOD_WIDTH + 4;

   reg [2:0] strapMeta_q;
   reg [2:0] strapSync_q;
   reg xtalMeta_q;
   reg xtalSync_q;
   reg xtalPrev_q;
   reg [PERIOD_WIDTH-1:0] gapCnt_q;
   reg [PERIOD_WIDTH-1:0] period_q;
   reg [ACC_WIDTH-1:0] acc_q;
   reg [ACC_WIDTH-1:0] acc_d;
   reg [3:0] syncCnt_q;
   reg [3:0] syncCnt_d;
   reg [3:0] factorHalf;
   reg cpuClock_d;
   wire xtalEdge;
   wire xtalRise;
   wire isDirect;
   wire isPrescale;
   wire isPll;
   wire monitorOn;
   wire runFree;
   wire countEn;
   wire freeTick;
   wire overflow;
   wire [ACC_WIDTH-1:0] accSum;
   wire [ACC_WIDTH-1:0] wrapLimit;
   wire pllToggle;
   wire [PERIOD_WIDTH-1:0] gapMax;
   wire [3:0] syncLimit;

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers
   // Strap chain has no reset so it tracks the pins while reset is held
   always @(posedge clk_sys) begin
      strapMeta_q <= clockStrapPins;
      strapSync_q <= strapMeta_q;
   end

   always @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         xtalMeta_q <= 1'b0;
         xtalSync_q <= 1'b0;
         xtalPrev_q <= 1'b0;
      end else begin
         xtalMeta_q <= crystalInputPin;
         xtalSync_q <= xtalMeta_q;
         xtalPrev_q <= xtalSync_q;
      end
   end

   assign xtalEdge = xtalSync_q ^ xtalPrev_q;
   assign xtalRise = xtalSync_q & ~xtalPrev_q;

   ////////////////////////////////////////////////////////////////////////////
   // Strap capture at the first edge after reset release
   always @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         clockMode_q <= `CCS_MODE_RESET;
         modeValid_q <= 1'b0;
      end else if (!modeValid_q) begin
         clockMode_q <= strapSync_q;
         modeValid_q <= 1'b1;
      end
   end

   assign isDirect = modeValid_q && clockMode_q == `CCS_MODE_DIRECT;
   assign isPrescale = modeValid_q && clockMode_q == `CCS_MODE_PRESCALE;
   assign isPll = modeValid_q && !isDirect && !isPrescale;

   always @* begin
      case (clockMode_q)
         `CCS_MODE_X4: factorHalf = `CCS_FH_X4;
         `CCS_MODE_X3: factorHalf = `CCS_FH_X3;
         `CCS_MODE_X2: factorHalf = `CCS_FH_X2;
         `CCS_MODE_X5: factorHalf = `CCS_FH_X5;
         `CCS_MODE_X15: factorHalf = `CCS_FH_X15;
         `CCS_MODE_X25: factorHalf = `CCS_FH_X25;
         default: factorHalf = `CCS_FH_NONE;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // System configuration: monitor disable bit
   always @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         oscMonitorDisable_q <= `CCS_MONDIS_RESET;
      end else if (sysConfigWrite) begin
         oscMonitorDisable_q <= sysConfigData[`CCS_MONDIS_BIT];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Oscillator monitor and failover
   assign monitorOn = (isDirect || isPrescale) && !oscMonitorDisable_q;
   // Free clock keeps running after failover since it is then the CPU clock
   assign runFree = monitorOn || clockFailed_q;
   assign countEn = monitorOn && !clockFailed_q;

   ccs_osc_monitor #(
      .FREE_HALF(FREE_HALF),
      .OVF_COUNT(OVF_COUNT)
   ) i_ccs_osc_monitor (
      .clk_sys(clk_sys),
      .resetn(resetn),
      .runFree(runFree),
      .countEn(countEn),
      .xtalEdge(xtalEdge),
      .freeTick_q(freeTick),
      .overflow_q(overflow)
   );

   always @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         clockFailed_q <= 1'b0;
         clockFailIrqFlag_q <= 1'b0;
         monitorActive_q <= 1'b0;
         pllEnable_q <= 1'b0;
      end else begin
         // Only reset clears the failover state
         if (overflow && countEn) begin
            clockFailed_q <= 1'b1;
         end
         // A new failure in the clear cycle wins over the clear
         if (overflow && countEn) begin
            clockFailIrqFlag_q <= 1'b1;
         end else if (irqFlagClear) begin
            clockFailIrqFlag_q <= 1'b0;
         end
         monitorActive_q <= countEn;
         pllEnable_q <= isPll || runFree;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Input period measurement for the PLL model
   assign gapMax = {PERIOD_WIDTH{1'b1}};

   always @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         gapCnt_q <= {PERIOD_WIDTH{1'b0}};
         period_q <= {PERIOD_WIDTH{1'b0}};
      end else if (xtalEdge) begin
         gapCnt_q <= {PERIOD_WIDTH{1'b0}};
         period_q <= (gapCnt_q == gapMax) ? gapMax : gapCnt_q + 1'b1;
      end else if (gapCnt_q != gapMax) begin
         gapCnt_q <= gapCnt_q + 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // PLL model: F output toggles per input transition
   // Fractional factors make the phase wander; resync bounds the error
   assign accSum = acc_q + {{(ACC_WIDTH-4){1'b0}}, factorHalf};
   assign wrapLimit = {3'b000, period_q, 1'b0};
   assign pllToggle = isPll && period_q != {PERIOD_WIDTH{1'b0}} && accSum >= wrapLimit;
   // Half-integer factors realign only after an even count of transitions
   assign syncLimit = factorHalf[0] ? factorHalf + 4'h1 : {1'b0, factorHalf[3:1]};

   always @* begin
      acc_d = acc_q;
      syncCnt_d = syncCnt_q;
      if (!isPll) begin
         acc_d = {ACC_WIDTH{1'b0}};
         syncCnt_d = 4'h0;
      end else if (xtalEdge && syncCnt_q + 4'h1 >= syncLimit) begin
         acc_d = {ACC_WIDTH{1'b0}};
         syncCnt_d = 4'h0;
      end else begin
         acc_d = pllToggle ? accSum - wrapLimit : accSum;
         if (xtalEdge) begin
            syncCnt_d = syncCnt_q + 4'h1;
         end
      end
   end

   always @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         acc_q <= {ACC_WIDTH{1'b0}};
         syncCnt_q <= 4'h0;
      end else begin
         acc_q <= acc_d;
         syncCnt_q <= syncCnt_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // CPU clock source mux
   always @* begin
      cpuClock_d = cpuClock_q;
      if (!modeValid_q) begin
         cpuClock_d = 1'b0;
      end else if (clockFailed_q) begin
         cpuClock_d = cpuClock_q ^ freeTick;
      end else if (isDirect) begin
         cpuClock_d = xtalSync_q;
      end else if (isPrescale) begin
         cpuClock_d = cpuClock_q ^ xtalRise;
      end else begin
         cpuClock_d = cpuClock_q ^ pllToggle;
      end
   end

   always @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         cpuClock_q <= 1'b0;
      end else begin
         cpuClock_q <= cpuClock_d;
      end
   end

endmodule // ccs_clock_select

// ==== verif/ccs_xtal_src.sv ====
`timescale 1ns/1ns
////////////////////////////////////////
module ccs_xtal_src #(
   parameter HALF_NS = 1000
) (
   // Bench control
   input wire run,
   input wire [2:0] strapCode,
   // Pins into the device
   output reg crystalInputPin,
   output wire [2:0] clockStrapPins
);
   // Board holds the strap level as long as the bench keeps the code
   assign clockStrapPins = strapCode;
   // A dead oscillator sticks at its last level; offset keeps edges off clk_sys
   initial begin
      crystalInputPin = 1'b0;
      #13;
      forever begin
         #HALF_NS;
         if (run) crystalInputPin = ~crystalInputPin;
      end
   end
endmodule // ccs_xtal_src

// ==== verif/ccs_clock_select_chk.sv ====
`timescale 1ns/1ns
`include "ccs_consts.vh"
module ccs_clock_select_chk #(
   parameter PERIOD_WIDTH = 12,
   parameter [3:0] FREE_HALF = `CCS_FREE_HALF,
   parameter [4:0] OVF_COUNT = `CCS_MON_OVF
) (
   // Clock and reset
   input wire clk_sys,
   input wire resetn,
   // Inputs
   input wire [2:0] clockStrapPins,
   input wire crystalInputPin,
   input wire sysConfigWrite,
   input wire [15:0] sysConfigData,
   input wire irqFlagClear,
   // Outputs
   input wire cpuClock_q,
   input wire pllEnable_q,
   input wire [2:0] clockMode_q,
   input wire modeValid_q,
   input wire oscMonitorDisable_q,
   input wire monitorActive_q,
   input wire clockFailed_q,
   input wire clockFailIrqFlag_q
);
   // Slack covers sync chain and free clock phase
   localparam integer FAIL_MIN = 2 * FREE_HALF * (OVF_COUNT - 1);
   localparam integer FAIL_MAX = 2 * FREE_HALF * OVF_COUNT + 16;
   wire monBit = sysConfigData[`CCS_MONDIS_BIT];
   wire monMode = clockMode_q == `CCS_MODE_DIRECT || clockMode_q == `CCS_MODE_PRESCALE;
   reg [7:0] quietCnt_q;
   reg pinSeen_q;
   always @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         quietCnt_q <= 8'h00;
         pinSeen_q <= 1'b0;
      end else begin
         pinSeen_q <= crystalInputPin;
         if (pinSeen_q != crystalInputPin) quietCnt_q <= 8'h00;
         else if (quietCnt_q != 8'hff) quietCnt_q <= quietCnt_q + 8'h01;
      end
   end
   ////////////////////////////////////////
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!resetn);
   strap_capture_a:
   assert property ($rose(modeValid_q) |-> clockMode_q == $past(clockStrapPins, 2))
      else $error("strap code not captured");
   cfg_readback_a:
   assert property (sysConfigWrite |=> oscMonitorDisable_q == $past(monBit))
      else $error("monitor disable bit not taken");
   mon_stop_a:
   assert property (oscMonitorDisable_q |=> !monitorActive_q) else $error("monitor still on");
   mon_mode_a:
   assert property (monitorActive_q || clockFailed_q |-> monMode) else $error("monitor in pll mode");
   fail_sticky_a:
   assert property (clockFailed_q |=> clockFailed_q && pllEnable_q) else $error("failover lost");
   fail_flag_a:
   assert property ($rose(clockFailed_q) |-> clockFailIrqFlag_q && quietCnt_q >= FAIL_MIN)
      else $error("failover early or without flag");
   fail_bound_a:
   assert property (monitorActive_q && quietCnt_q >= FAIL_MAX |-> clockFailed_q)
      else $error("failover missed");
   direct_follow_a:
   assert property (clockMode_q == `CCS_MODE_DIRECT && $past(modeValid_q, 4) && !clockFailed_q
      |-> cpuClock_q == $past(crystalInputPin, 3)) else $error("cpu clock not following input");
   cover property ($rose(clockFailed_q));
   cover property (irqFlagClear && clockFailIrqFlag_q);
   cover property (sysConfigWrite && monBit);
endmodule // ccs_clock_select_chk
bind ccs_clock_select ccs_clock_select_chk #(.PERIOD_WIDTH(PERIOD_WIDTH),
   .FREE_HALF(FREE_HALF), .OVF_COUNT(OVF_COUNT)) i_ccs_clock_select_chk (
   .clk_sys(clk_sys), .resetn(resetn), .clockStrapPins(clockStrapPins),
   .crystalInputPin(crystalInputPin), .sysConfigWrite(sysConfigWrite),
   .sysConfigData(sysConfigData), .irqFlagClear(irqFlagClear), .cpuClock_q(cpuClock_q),
   .pllEnable_q(pllEnable_q), .clockMode_q(clockMode_q), .modeValid_q(modeValid_q),
   .oscMonitorDisable_q(oscMonitorDisable_q), .monitorActive_q(monitorActive_q),
   .clockFailed_q(clockFailed_q), .clockFailIrqFlag_q(clockFailIrqFlag_q));

// ==== verif/test_ccs_clock_select.sv ====
`timescale 1ns/1ns
`include "ccs_consts.vh"
module test_ccs_clock_select;
   localparam [3:0] FH = 4'h2;
   localparam [7:0] FREE_RISES = 400 / (2 * FH);
   reg clk_sys = 1'b0;
   reg resetn = 1'b0;
   reg [2:0] strapCode = `CCS_MODE_RESET;
   reg xtalRun = 1'b1;
   reg sysConfigWrite = 1'b0;
   reg [15:0] sysConfigData = 16'h0000;
   reg irqFlagClear = 1'b0;
   wire [2:0] clockStrapPins, clockMode_q;
   wire crystalInputPin, cpuClock_q, pllEnable_q, modeValid_q, oscMonitorDisable_q;
   wire monitorActive_q, clockFailed_q, clockFailIrqFlag_q;
   integer badCount = 0;
   integer checkCount = 0;
   integer n, k;
   always #25 clk_sys = ~clk_sys;
   ccs_xtal_src i_ccs_xtal_src (.run(xtalRun), .strapCode(strapCode),
      .crystalInputPin(crystalInputPin), .clockStrapPins(clockStrapPins));
   ccs_clock_select #(.FREE_HALF(FH)) i_ccs_clock_select (.clk_sys(clk_sys), .resetn(resetn),
      .clockStrapPins(clockStrapPins), .crystalInputPin(crystalInputPin),
      .sysConfigWrite(sysConfigWrite), .sysConfigData(sysConfigData),
      .irqFlagClear(irqFlagClear), .cpuClock_q(cpuClock_q), .pllEnable_q(pllEnable_q),
      .clockMode_q(clockMode_q), .modeValid_q(modeValid_q),
      .oscMonitorDisable_q(oscMonitorDisable_q), .monitorActive_q(monitorActive_q),
      .clockFailed_q(clockFailed_q), .clockFailIrqFlag_q(clockFailIrqFlag_q));
   ////////////////////////////////////////
   task wrapUp;
      begin
         $display("checks %0d mismatches %0d", checkCount, badCount);
         if (badCount == 0 && checkCount > 0)
            $display("verification passed");
         else
            $display("verification failed");
         $finish;
      end
   endtask
   task check(input [8*12-1:0] what, input [7:0] exp, input [7:0] got);
      begin
         checkCount = checkCount + 1;
         if (got !== exp) begin
            badCount = badCount + 1;
            $display("wrong value %0s expected %h seen %h", what, exp, got);
         end
      end
   endtask
   task waitCyc(input integer c);
      repeat (c) @(negedge clk_sys);
   endtask
   task doReset(input [2:0] c);
      begin
         resetn = 1'b0;
         strapCode = c;
         waitCyc(6);
         resetn = 1'b1;
         waitCyc(4);
         check("mode", {5'h00, c}, {5'h00, clockMode_q});
         check("valid", 8'h01, {7'h00, modeValid_q});
      end
   endtask
   // Rising edges of the cpu clock over a window, sampled between edges
   task countRises(input integer cyc);
      reg prev;
      begin
         n = 0;
         prev = cpuClock_q;
         repeat (cyc) begin
            @(negedge clk_sys);
            if (cpuClock_q === 1'b1 && prev === 1'b0) n = n + 1;
            prev = cpuClock_q;
         end
      end
   endtask
   // Window start phase may cost or gain one edge
   function [7:0] near(input [7:0] e);
      near = (n + 1 >= e && n <= e + 1) ? e : n[7:0];
   endfunction
   // Rises in ten input periods for each strap code
   function [7:0] expRise(input [2:0] c);
      case (c)
         3'h7: expRise = 8'h28;
         3'h6: expRise = 8'h1e;
         3'h5: expRise = 8'h14;
         3'h4: expRise = 8'h32;
         3'h3: expRise = 8'h0a;
         3'h2: expRise = 8'h0f;
         3'h1: expRise = 8'h05;
         default: expRise = 8'h19;
      endcase
   endfunction
   ////////////////////////////////////////
   initial begin
      begin : scenarios
      waitCyc(1);
      for (k = 0; k < 8; k = k + 1) begin
         doReset(k[2:0]);
         check("monActive", {7'h00, k == 1 || k == 3}, {7'h00, monitorActive_q});
         check("pllOn", 8'h01, {7'h00, pllEnable_q});
         strapCode = ~strapCode;
         waitCyc(200);
         check("modeHeld", {5'h00, k[2:0]}, {5'h00, clockMode_q});
         countRises(400);
         check("cpuRises", expRise(k[2:0]), near(expRise(k[2:0])));
      end
      doReset(`CCS_MODE_DIRECT);
      waitCyc(100);
      xtalRun = 1'b0;
      n = 0;
      while (clockFailed_q !== 1'b1 && n < 200) begin
         waitCyc(1);
         n = n + 1;
      end
      check("failTime", 8'h01, {7'h00, n >= 40 && n <= 80});
      if (n == 200) disable scenarios;
      check("irqFlag", 8'h01, {7'h00, clockFailIrqFlag_q});
      xtalRun = 1'b1;
      countRises(400);
      check("freeRises", FREE_RISES, near(FREE_RISES));
      check("stillFail", 8'h01, {7'h00, clockFailed_q});
      irqFlagClear = 1'b1;
      waitCyc(1);
      irqFlagClear = 1'b0;
      waitCyc(1);
      check("flagClear", 8'h00, {7'h00, clockFailIrqFlag_q});
      doReset(`CCS_MODE_PRESCALE);
      check("failReset", 8'h00, {7'h00, clockFailed_q});
      sysConfigWrite = 1'b1;
      sysConfigData = 16'h0001 << `CCS_MONDIS_BIT;
      waitCyc(1);
      sysConfigWrite = 1'b0;
      waitCyc(2);
      check("monDisable", 8'h01, {7'h00, oscMonitorDisable_q});
      check("monOff", 8'h00, {7'h00, monitorActive_q});
      check("pllOff", 8'h00, {7'h00, pllEnable_q});
      xtalRun = 1'b0;
      waitCyc(150);
      check("noFailDis", 8'h00, {7'h00, clockFailed_q});
      xtalRun = 1'b1;
      doReset(`CCS_MODE_X4);
      xtalRun = 1'b0;
      waitCyc(150);
      check("noFailPll", 8'h00, {7'h00, clockFailed_q});
      end
      wrapUp;
   end
endmodule // test_ccs_clock_select
